// ---- rcc_rate_corr.sv ----
// Rate correction term calculator with Avalon-MM configuration slave
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module rcc_rate_corr
  import rcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Measurement and schedule events
  input wire logic config_state,
  input wire logic even_cycle_start,
  input wire logic odd_static_end,
  input wire logic meas_valid,
  input wire logic meas_odd,
  input wire logic meas_chan,
  input wire logic [2:0] meas_id,
  input wire logic [VW-1:0] meas_ap_ts,
  input wire logic [VW-1:0] meas_ref_ts,
  input wire logic [VW-1:0] offset_corr_term,
  // Results
  output logic [VW-1:0] rate_corr_term,
  output logic [VW-1:0] offset_applied,
  output logic rate_done,
  output logic too_few_terms_err,
  output logic out_of_limit_err,
  output logic sync_ok,
  output logic passive_req,
  output logic halt_req
);
  localparam int RC_BOUND = 16;

  rcc_regs_type s;
  rcc_regs_type n;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Halve toward zero
  function automatic logic signed [AW-1:0] div2(input logic signed [AW-1:0] x);
    logic signed [AW-1:0] t;
    t = x + {{(AW-1){1'b0}}, x[AW-1]};
    return t >>> 1;
  endfunction

  // Host control code to signed step
  function automatic logic signed [AW-1:0] ext_term(input logic [1:0] c,
                                                    input logic [14:0] step);
    logic signed [AW-1:0] m;
    m = $signed({4'h0, step});
    if (c == 2'h1) return m;
    else if (c == 2'h3) return -m;
    else return '0;
  endfunction

  // Value of given rank among first cnt list entries
  function automatic logic signed [LW-1:0] pick(input logic [IDS-1:0][LW-1:0] l,
                                                input logic [3:0] cnt,
                                                input logic [3:0] r);
    logic signed [LW-1:0] res;
    logic [3:0] rank;
    res = '0;
    rank = '0;
    for (int i = 0; i < IDS; i++) begin
      rank = '0;
      for (int j = 0; j < IDS; j++) begin
        if (4'(j) < cnt && ($signed(l[j]) < $signed(l[i]) ||
            (l[j] == l[i] && j < i))) begin
          rank = rank + 4'h1;
        end
      end
      if (4'(i) < cnt && rank == r) res = $signed(l[i]);
    end
    return res;
  endfunction

  // Clamp to symmetric bound
  function automatic logic signed [AW-1:0] clamp(input logic signed [AW-1:0] x,
                                                 input logic [14:0] lim);
    logic signed [AW-1:0] m;
    m = $signed({4'h0, lim});
    if (x > m) return m;
    else if (x < -m) return -m;
    else return x;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic signed [LW-1:0] da;
  logic signed [LW-1:0] db;
  logic signed [AW-1:0] t;
  logic signed [AW-1:0] o;
  logic [3:0] k;
  logic [3:0] need;
  logic va;
  logic vb;

  always_comb begin
    n = s;
    n.done = 1'b0;
    da = '0;
    db = '0;
    t = '0;
    o = '0;
    k = '0;
    va = 1'b0;
    vb = 1'b0;
    need = (s.ctrl[CTRL_COLD] && s.ctrl[1:0] != MODE_DIST) ? 4'h0 : 4'h1;
    // Bus handshake, one wait cycle per access
    if (!s.waitreq) begin
      n.waitreq = 1'b1;
    end else if (avs_read || avs_write) begin
      n.waitreq = 1'b0;
      case (avs_address)
        REG_CTRL: n.rdata = {28'h0, s.ctrl};
        REG_DAMP: n.rdata = {17'h0, s.damp};
        REG_RLIM: n.rdata = {17'h0, s.rlim};
        REG_OLIM: n.rdata = {17'h0, s.olim};
        REG_RSTEP: n.rdata = {17'h0, s.rstep};
        REG_OSTEP: n.rdata = {17'h0, s.ostep};
        REG_HOST: n.rdata = {28'h0, s.host};
        REG_STAT: n.rdata = {27'h0, s.st != ST_IDLE, s.sync_ok, s.oob, s.too_few, 1'b0};
        REG_RATE: n.rdata = {{16{s.rate[VW-1]}}, s.rate};
        REG_OFFS: n.rdata = {{16{s.offs[VW-1]}}, s.offs};
        REG_CNT: n.rdata = {28'h0, s.cnt};
        default: n.rdata = 32'h0;
      endcase
    end
    // Writes land at the edge where waitrequest is low
    if (avs_write && !s.waitreq) begin
      if (avs_address == REG_HOST) n.host = avs_writedata[3:0];
      if (config_state) begin
        case (avs_address)
          REG_CTRL: n.ctrl = avs_writedata[3:0];
          REG_DAMP: n.damp = avs_writedata[14:0];
          REG_RLIM: n.rlim = avs_writedata[14:0];
          REG_OLIM: n.olim = avs_writedata[14:0];
          REG_RSTEP: n.rstep = avs_writedata[14:0];
          REG_OSTEP: n.ostep = avs_writedata[14:0];
          default: n.ctrl = s.ctrl;
        endcase
      end
    end
    // Deviation storage
    if (even_cycle_start) n.dval = '0;
    if (meas_valid) begin
      n.dev[meas_odd][meas_chan][meas_id] = meas_ap_ts - meas_ref_ts;
      n.dval[meas_odd][meas_chan][meas_id] = 1'b1;
    end
    // Calculation sequence
    case (s.st)
      ST_IDLE: begin
        if (odd_static_end) begin
          n.st = ST_PAIR;
          n.idx = '0;
          n.cnt = '0;
          n.too_few = 1'b0;
          n.oob = 1'b0;
          o = $signed({{(AW-VW){offset_corr_term[VW-1]}}, offset_corr_term});
          n.off_oob = clamp(o, s.olim) != o;
          o = clamp(o, s.olim) + ext_term(s.host[3:2], s.ostep);
          n.offs = o[VW-1:0];
        end
      end
      ST_PAIR: begin
        va = s.dval[0][0][s.idx[2:0]] && s.dval[1][0][s.idx[2:0]];
        vb = s.dval[0][1][s.idx[2:0]] && s.dval[1][1][s.idx[2:0]];
        da = $signed({s.dev[1][0][s.idx[2:0]][VW-1], s.dev[1][0][s.idx[2:0]]}) -
             $signed({s.dev[0][0][s.idx[2:0]][VW-1], s.dev[0][0][s.idx[2:0]]});
        db = $signed({s.dev[1][1][s.idx[2:0]][VW-1], s.dev[1][1][s.idx[2:0]]}) -
             $signed({s.dev[0][1][s.idx[2:0]][VW-1], s.dev[0][1][s.idx[2:0]]});
        if (va && vb) begin
          t = div2(AW'(da) + AW'(db));
        end else if (va) begin
          t = AW'(da);
        end else begin
          t = AW'(db);
        end
        if (va || vb) begin
          n.list[s.cnt[2:0]] = t[LW-1:0];
          n.cnt = s.cnt + 4'h1;
        end
        n.idx = s.idx + 4'h1;
        if (s.idx == 4'(IDS - 1)) n.st = ST_FTM;
      end
      ST_FTM: begin
        k = (s.cnt <= 4'h2) ? 4'h0 : ((s.cnt <= 4'h7) ? 4'h1 : 4'h2);
        if (s.cnt == 4'h0) begin
          n.acc = '0;
        end else begin
          n.acc = div2(AW'(pick(s.list, s.cnt, k)) +
                       AW'(pick(s.list, s.cnt, s.cnt - 4'h1 - k)));
        end
        n.too_few = (s.cnt < need) && !s.off_oob;
        n.st = ST_DAMP;
      end
      ST_DAMP: begin
        t = $signed({4'h0, s.damp});
        if (s.acc > t) n.acc = s.acc - t;
        else if (s.acc < -t) n.acc = s.acc + t;
        else n.acc = '0;
        n.st = ST_EXT;
      end
      ST_EXT: begin
        n.acc = s.acc + ext_term(s.host[1:0], s.rstep);
        n.st = ST_LIMIT;
      end
      ST_LIMIT: begin
        t = clamp(s.acc, s.rlim);
        n.rate = t[VW-1:0];
        n.oob = (t != s.acc) || s.off_oob;
        n.sync_ok = (t == s.acc) && !s.off_oob;
        n.passive = n.oob && !s.ctrl[CTRL_HALT];
        n.halt = n.oob && s.ctrl[CTRL_HALT];
        n.done = 1'b1;
        n.st = ST_IDLE;
      end
      default: n.st = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ctrl <= CTRL_RST;
      s.rlim <= LIM_RST;
      s.olim <= LIM_RST;
      s.waitreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from state
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign rate_corr_term = s.rate;
  assign offset_applied = s.offs;
  assign rate_done = s.done;
  assign too_few_terms_err = s.too_few;
  assign out_of_limit_err = s.oob;
  assign sync_ok = s.sync_ok;
  assign passive_req = s.passive;
  assign halt_req = s.halt;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_start;
    s.st == ST_IDLE && odd_static_end;
  endsequence
  sequence seq_pair_walk;
    (s.st == ST_PAIR)[*8] ##1 (s.st == ST_FTM);
  endsequence

  a_pair_walk_order: assert property (seq_start |=> seq_pair_walk)
    else $error("pair walk out of order");
  a_result_deadline: assert property (seq_start |-> ##[1:RC_BOUND] s.done)
    else $error("rate result late");
  a_rate_clamped: assert property (s.done |-> ($signed(s.rate) <= $signed({1'b0, s.rlim}) &&
    $signed(s.rate) >= -$signed({1'b0, s.rlim})))
    else $error("rate beyond limit");
  a_oob_flagged: assert property (s.st == ST_LIMIT && s.acc > $signed({4'h0, s.rlim})
    |=> s.oob && s.rate == {1'b0, s.rlim})
    else $error("exceeding term not clamped");
  a_damp_zeroes: assert property (s.st == ST_DAMP && s.acc <= $signed({4'h0, s.damp}) &&
    s.acc >= -$signed({4'h0, s.damp}) |=> s.acc == 0)
    else $error("damping not applied");
  a_ext_added: assert property (s.st == ST_EXT |=>
    s.acc == $past(s.acc) + ext_term($past(s.host[1:0]), $past(s.rstep)))
    else $error("external term lost");
  a_too_few_terms_err: assert property (s.st == ST_FTM && s.cnt == 0 && need == 1 && !s.off_oob
    |=> s.too_few)
    else $error("too_few_terms_err not flagged");
  a_sync_state: assert property (s.done |-> s.sync_ok == !s.oob &&
    (s.halt || s.passive) == s.oob)
    else $error("sync status mismatch");
  a_cfg_locked: assert property (avs_write && !s.waitreq && !config_state &&
    avs_address == REG_RSTEP |=> $stable(s.rstep))
    else $error("step changed outside config");
endmodule

// ---- rcc_pkg.sv ----
// Constants and types for the rate correction calculator
package rcc_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int VW = 16;
  localparam int IDS = 8;
  localparam int LW = 17;
  localparam int AW = 19;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_DAMP = 6'h04;
  localparam logic [5:0] REG_RLIM = 6'h08;
  localparam logic [5:0] REG_OLIM = 6'h0c;
  localparam logic [5:0] REG_RSTEP = 6'h10;
  localparam logic [5:0] REG_OSTEP = 6'h14;
  localparam logic [5:0] REG_HOST = 6'h18;
  localparam logic [5:0] REG_STAT = 6'h1c;
  localparam logic [5:0] REG_RATE = 6'h20;
  localparam logic [5:0] REG_OFFS = 6'h24;
  localparam logic [5:0] REG_CNT = 6'h28;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_COLD = 2;
  localparam int CTRL_HALT = 3;
  localparam logic [1:0] MODE_DIST = 2'h0;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [14:0] LIM_RST = 15'h0000;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int RATE_CALC_DEADLINE_MT = 2;
  localparam int MACROTICK_NS = 1000;
  localparam int CLK_NS = 5;
  localparam int RATE_CALC_DEADLINE_CYC = (RATE_CALC_DEADLINE_MT * MACROTICK_NS) / CLK_NS;
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum {ST_IDLE, ST_PAIR, ST_FTM, ST_DAMP, ST_EXT, ST_LIMIT} rcc_state_type;
  typedef struct packed {
    rcc_state_type st;
    logic [1:0][1:0][IDS-1:0][VW-1:0] dev;
    logic [1:0][1:0][IDS-1:0] dval;
    logic [IDS-1:0][LW-1:0] list;
    logic [3:0] idx;
    logic [3:0] cnt;
    logic signed [AW-1:0] acc;
    logic off_oob;
    logic [3:0] ctrl;
    logic [14:0] damp;
    logic [14:0] rlim;
    logic [14:0] olim;
    logic [14:0] rstep;
    logic [14:0] ostep;
    logic [3:0] host;
    logic waitreq;
    logic [31:0] rdata;
    logic [VW-1:0] rate;
    logic [VW-1:0] offs;
    logic too_few;
    logic oob;
    logic sync_ok;
    logic done;
    logic passive;
    logic halt;
  } rcc_regs_type;
endpackage

// ---- rcc_meas_model.sv ----
// Measurement source model: stored deviations and schedule events
`timescale 1ns/1ps
module rcc_meas_model
  import rcc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Schedule events
  output logic even_cycle_start,
  output logic odd_static_end,
  // Deviation measurements
  output logic meas_valid,
  output logic meas_odd,
  output logic meas_chan,
  output logic [2:0] meas_id,
  output logic [VW-1:0] meas_ap_ts,
  output logic [VW-1:0] meas_ref_ts
);
  logic [VW-1:0] ref_ts = 16'h1234;
  // Quiet lines at start
  initial begin
    even_cycle_start = 1'b0;
    odd_static_end = 1'b0;
    meas_valid = 1'b0;
    meas_odd = 1'b0;
    meas_chan = 1'b0;
    meas_id = 3'h0;
    meas_ap_ts = 16'h0000;
    meas_ref_ts = 16'h0000;
  end
  // One-cycle pulse: 0 clears the store, 1 ends the odd static segment
  task automatic pulse(input logic odd_end);
    @(posedge clk);
    even_cycle_start <= !odd_end;
    odd_static_end <= odd_end;
    @(posedge clk);
    even_cycle_start <= 1'b0;
    odd_static_end <= 1'b0;
  endtask
  // One received sync frame with the given deviation
  task automatic put(input logic odd, input logic ch, input logic [2:0] id,
                     input logic [VW-1:0] dev);
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_odd <= odd;
    meas_chan <= ch;
    meas_id <= id;
    meas_ref_ts <= ref_ts;
    meas_ap_ts <= ref_ts + dev;
    @(posedge clk);
    meas_valid <= 1'b0;
    meas_id <= ~id; // Stale identifier and timestamps scrambled
    meas_ref_ts <= ~ref_ts;
    meas_ap_ts <= ~(ref_ts + dev);
    ref_ts <= ref_ts + 16'h0b3d;
  endtask
endmodule

// ---- rcc_rate_corr_bench.sv ----
// Self-checking bench for the rate correction calculator
`timescale 1ns/1ps
module rcc_rate_corr_bench
  import rcc_pkg::*;
;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, config_state;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic even_cycle_start, odd_static_end, meas_valid, meas_odd, meas_chan;
  logic [2:0] meas_id;
  logic [VW-1:0] meas_ap_ts, meas_ref_ts, offset_corr_term, rate_corr_term, offset_applied;
  logic rate_done, too_few_terms_err, out_of_limit_err, sync_ok, passive_req, halt_req;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [1:0] hc [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
  logic [15:0] hx [4] = '{16'h0005, 16'hfffb, 16'h0000, 16'h0000};
  logic [15:0] ho [4] = '{16'h0003, 16'hfffd, 16'h0000, 16'h0000};
  logic [3:0] cm [5] = '{4'h0, 4'h6, 4'h5, 4'h2, 4'h4};
  logic cf [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  rcc_rate_corr u_rcc_rate_corr (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .config_state(config_state), .even_cycle_start(even_cycle_start),
    .odd_static_end(odd_static_end), .meas_valid(meas_valid), .meas_odd(meas_odd),
    .meas_chan(meas_chan), .meas_id(meas_id), .meas_ap_ts(meas_ap_ts),
    .meas_ref_ts(meas_ref_ts), .offset_corr_term(offset_corr_term),
    .rate_corr_term(rate_corr_term), .offset_applied(offset_applied), .rate_done(rate_done),
    .too_few_terms_err(too_few_terms_err), .out_of_limit_err(out_of_limit_err),
    .sync_ok(sync_ok), .passive_req(passive_req), .halt_req(halt_req));
  rcc_meas_model u_rcc_meas_model (.clk(clk), .even_cycle_start(even_cycle_start),
    .odd_static_end(odd_static_end), .meas_valid(meas_valid), .meas_odd(meas_odd),
    .meas_chan(meas_chan), .meas_id(meas_id), .meas_ap_ts(meas_ap_ts),
    .meas_ref_ts(meas_ref_ts));

  // ---------------------------------------------------------------
  // Clock, hang guard and closing report
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Access and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus access held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [5:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(what, rdv, exp);
  endtask
  // Reset, configuration state and offset term, changed at a rising edge
  task automatic set_pins(input logic r, input logic cs, input logic [VW-1:0] ofs);
    rst_n <= r;
    config_state <= cs;
    offset_corr_term <= ofs;
  endtask
  // Even and odd deviations on one channel and identifier
  task automatic pr(input logic [2:0] id, input logic ch, input logic [VW-1:0] d);
    u_rcc_meas_model.pulse(1'b0);
    u_rcc_meas_model.put(1'b0, ch, id, 16'h0064);
    u_rcc_meas_model.put(1'b1, ch, id, 16'h0064 + d);
  endtask
  // Start a calculation, wait for the result, check the flags
  task automatic run(input string nm, input logic few, input logic oob);
    int n;
    n = 0;
    u_rcc_meas_model.pulse(1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (rate_done !== 1'b1);
    chk("latency", n <= RATE_CALC_DEADLINE_CYC, 1'b1);
    chk("too_few", too_few_terms_err, few);
    chk("out_of_limit", out_of_limit_err, oob);
    if (!few) chk("sync_ok", sync_ok, !oob);
    $display("test %s done", nm);
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    config_state = 1'b1;
    offset_corr_term = 16'h0000;
    repeat (20) @(posedge clk);
    set_pins(1'b1, 1'b1, 16'h0000);
    rdc("rlim_reset", REG_RLIM, 32'h0);
    rdc("unmapped", 6'h3c, 32'h0);
    acc(1'b1, REG_RLIM, 32'h0400);
    acc(1'b1, REG_OLIM, 32'h0064);
    acc(1'b1, REG_RSTEP, 32'h0005);
    acc(1'b1, REG_OSTEP, 32'h0003);
    rdc("rlim", REG_RLIM, 32'h0400);
    // Pairing, averaging and midpoint selection
    pr(3'h0, 1'b0, 16'h0014);
    run("single", 1'b0, 1'b0);
    chk("rate", rate_corr_term, 16'h0014);
    pr(3'h1, 1'b0, 16'hfff6);
    u_rcc_meas_model.put(1'b0, 1'b1, 3'h1, 16'h0064);
    u_rcc_meas_model.put(1'b1, 1'b1, 3'h1, 16'h005d);
    run("mean", 1'b0, 1'b0);
    chk("rate", rate_corr_term, 16'hfff8);
    pr(3'h0, 1'b0, 16'h0005);
    u_rcc_meas_model.put(1'b0, 1'b0, 3'h1, 16'h0064);
    u_rcc_meas_model.put(1'b1, 1'b0, 3'h1, 16'h00c8);
    u_rcc_meas_model.put(1'b0, 1'b0, 3'h2, 16'h0064);
    u_rcc_meas_model.put(1'b1, 1'b0, 3'h2, 16'h0032);
    run("three", 1'b0, 1'b0);
    chk("rate", rate_corr_term, 16'h0005);
    u_rcc_meas_model.pulse(1'b0);
    for (int i = 0; i < 8; i++) begin
      u_rcc_meas_model.put(1'b0, 1'b0, i[2:0], 16'h0064);
      u_rcc_meas_model.put(1'b1, 1'b0, i[2:0], 16'h0063 - i[15:0]);
    end
    run("eight", 1'b0, 1'b0);
    chk("rate", rate_corr_term, 16'hfffc);
    rdc("pair_count", REG_CNT, 32'h8);
    // Damping
    acc(1'b1, REG_DAMP, 32'h0004);
    pr(3'h0, 1'b0, 16'h000a);
    run("damp", 1'b0, 1'b0);
    chk("rate", rate_corr_term, 16'h0006);
    acc(1'b1, REG_DAMP, 32'h0000);
    // Host rate and offset control codes
    set_pins(1'b1, 1'b1, 16'h000a);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, REG_HOST, {28'h0, hc[i], hc[i]});
      pr(3'h0, 1'b0, 16'h0014);
      run("host", 1'b0, 1'b0);
      chk("rate", rate_corr_term, 16'(16'h0014 + hx[i]));
      chk("offset", offset_applied, 16'(16'h000a + ho[i]));
    end
    acc(1'b1, REG_HOST, 32'h0);
    set_pins(1'b1, 1'b1, 16'h0000);
    // Limits, clamping and error reaction
    acc(1'b1, REG_RLIM, 32'h0032);
    pr(3'h0, 1'b0, 16'h00c8);
    run("clamp_hi", 1'b0, 1'b1);
    chk("rate", rate_corr_term, 16'h0032);
    chk("react", {passive_req, halt_req}, 2'b10);
    acc(1'b1, REG_CTRL, 32'h0008);
    pr(3'h0, 1'b0, 16'hff38);
    run("clamp_lo", 1'b0, 1'b1);
    chk("rate", rate_corr_term, 16'hffce);
    chk("react", {passive_req, halt_req}, 2'b01);
    rdc("rate_reg", REG_RATE, 32'hffffffce);
    rdc("status", REG_STAT, 32'h00000004);
    pr(3'h0, 1'b0, 16'h0032);
    run("at_limit", 1'b0, 1'b0);
    chk("rate", rate_corr_term, 16'h0032);
    // Required pair count per mode and role
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, REG_CTRL, {28'h0, cm[i]});
      u_rcc_meas_model.pulse(1'b0);
      run("pair_count", cf[i], 1'b0);
    end
    u_rcc_meas_model.pulse(1'b0);
    u_rcc_meas_model.put(1'b0, 1'b0, 3'h3, 16'h0064);
    u_rcc_meas_model.put(1'b1, 1'b1, 3'h3, 16'h0078);
    run("cross_channel", 1'b1, 1'b0);
    set_pins(1'b1, 1'b1, 16'h00c8);
    u_rcc_meas_model.pulse(1'b0);
    run("offset_oob", 1'b0, 1'b1);
    chk("offset", offset_applied, 16'h0064);
    rdc("offs_reg", REG_OFFS, 32'h00000064);
    // Step sizes locked outside configuration
    set_pins(1'b1, 1'b0, 16'h00c8);
    acc(1'b1, REG_RSTEP, 32'h0009);
    rdc("rstep_lock", REG_RSTEP, 32'h0005);
    acc(1'b1, REG_HOST, 32'h0001);
    rdc("host", REG_HOST, 32'h0001);
    // Mid-run reset clears configuration and results
    set_pins(1'b0, 1'b1, 16'h0000);
    repeat (2) @(posedge clk);
    set_pins(1'b1, 1'b1, 16'h0000);
    chk("rate_rst", rate_corr_term, 16'h0000);
    chk("oob_rst", out_of_limit_err, 1'b0);
    rdc("rlim_rst", REG_RLIM, 32'h0);
    $display("test reset done");
    stop_test();
  end
endmodule
